//--- hdl/cfg_hdr_defines.svh
// constants of the configuration header slice: offsets, field positions, values
`ifndef CFG_HDR_DEFINES_SVH
`define CFG_HDR_DEFINES_SVH

// byte offsets in configuration space
`define OFF_CMD            8'h04
`define OFF_STS            8'h06
`define OFF_RID            8'h08
`define OFF_CC             8'h09
`define OFF_CLS            8'h0c
`define OFF_MLT            8'h0d
`define OFF_HEADER_KIND_REG          8'h0e
// dword alignment mask for the byte address
`define DWORD_MASK         8'hfc
// lane of the status half within the command/status dword
`define STS_LSB            16

// status field positions
`define STS_DPE_BIT        15
`define STS_SSE_BIT        14
`define STS_RMA_BIT        13
`define STS_RTA_BIT        12
`define STS_DPD_BIT        8
// command field positions
`define PARITY_RESPONSE_ENABLE_BIT        6

// implementation straps (arbitrary neutral values)
`define SEL_TIMING_VAL     2'h0
`define FAST_B2B_VAL       1'b0
`define HIGH_SPEED_VAL     1'b0
`define STEPPING_VAL       8'h01
`define MULTI_FUNC_VAL     1'b0
`define PARITY_SUPPORTED   1'b1

// fixed codes
`define BASE_CLASS_VAL     8'h01
`define SUB_CLASS_VAL      8'h08
`define HOST_IF_VAL        8'h02
`define HDR_LAYOUT_VAL     7'h00
`define MLT_VAL            8'h00
`define CAP_LIST_VAL       1'b1

// reset values
`define CLS_RST            8'h00
`define PEE_RST            1'b0
`define FLAGS_RST          5'h00

`endif

//--- hdl/cfg_hdr_pkg.sv
// types shared by the configuration header slice
package cfg_hdr_pkg;
	// index of each sticky status flag inside the flag vector
	typedef enum logic [2:0] {
		FLG_DPD = 3'b000,
		FLG_RTA = 3'b001,
		FLG_RMA = 3'b010,
		FLG_SSE = 3'b011,
		FLG_DPE = 3'b100
	} flag_idx_t;
	// one bit per sticky status flag
	typedef logic [4:0] flag_vec_t;
	// configuration byte address and dword data
	typedef logic [7:0]  cfg_addr_t;
	typedef logic [31:0] cfg_word_t;
endpackage

//--- hdl/status_evt_if.sv
// carrier of status events, clears and flag state between top and flag bank
`timescale 1ns/1ns
`default_nettype none
interface status_evt_if;
	import cfg_hdr_pkg::*;
	flag_vec_t evt;     // one-cycle set requests
	flag_vec_t clr;     // one-cycle write-one-to-clear requests
	flag_vec_t flags;   // current sticky flag state
	modport src   (output evt, output clr, input flags);
	modport bank  (input evt, input clr, output flags);
endinterface
`default_nettype wire

//--- hdl/status_flags.sv
// bank of sticky status flags, set by hardware and cleared by writing one
`timescale 1ns/1ns
`default_nettype none
`include "cfg_hdr_defines.svh"
module status_flags (
	input  wire logic   sys_clk,
	input  wire logic   srst,
	status_evt_if.bank  sef
);
	import cfg_hdr_pkg::*;

	flag_vec_t flags_q;  // sticky flag state

	// one flop per flag; a set in the clearing cycle wins
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_flag
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					flags_q[gi] <= 1'b0;
				end else if (sef.evt[gi]) begin
					flags_q[gi] <= 1'b1;
				end else if (sef.clr[gi]) begin
					flags_q[gi] <= 1'b0;
				end
			end

			a_flag_sets:
			assert property (@(posedge sys_clk) disable iff (srst)
				sef.evt[gi] |=> flags_q[gi] [*1])
			else $error("flag not set after event");

			a_flag_clears:
			assert property (@(posedge sys_clk) disable iff (srst)
				(sef.clr[gi] && !sef.evt[gi]) |=> !flags_q[gi])
			else $error("flag not cleared by write of one");

			a_flag_sticks:
			assert property (@(posedge sys_clk) disable iff (srst)
				(!sef.evt[gi] && !sef.clr[gi]) |=> $stable(flags_q[gi]))
			else $error("flag changed without cause");
		end
	endgenerate

	assign sef.flags = flags_q;

	c_set_and_clear: cover property (@(posedge sys_clk) disable iff (srst)
		(sef.evt != 5'h00) && ((sef.evt & sef.clr) != 5'h00));
endmodule
`default_nettype wire

//--- hdl/cfg_read_mux.sv
// assembles the read dword of the header slice from flags and fixed fields
`timescale 1ns/1ns
`default_nettype none
`include "cfg_hdr_defines.svh"
module cfg_read_mux (
	input  wire logic             rd_addr,
	input  wire cfg_hdr_pkg::cfg_addr_t byte_addr,
	input  wire cfg_hdr_pkg::flag_vec_t flags,
	input  wire logic             pee,
	input  wire logic             intx,
	input  wire logic [7:0]       cache_line_size_reg,
	output cfg_hdr_pkg::cfg_word_t word
);
	import cfg_hdr_pkg::*;

	cfg_addr_t  base;     // dword-aligned address
	logic [15:0] sts;     // assembled status half
	logic [15:0] cmd;     // command half, only the parity enable lives here

	// status half layout, reserved and unsupported bits held at zero
	always_comb begin
		sts = 16'h0000;
		sts[`STS_DPE_BIT] = flags[FLG_DPE];
		sts[`STS_SSE_BIT] = flags[FLG_SSE];
		sts[`STS_RMA_BIT] = flags[FLG_RMA];
		sts[`STS_RTA_BIT] = flags[FLG_RTA];
		sts[11] = 1'b0;
		sts[10:9] = `SEL_TIMING_VAL;
		sts[`STS_DPD_BIT] = flags[FLG_DPD];
		sts[7] = `FAST_B2B_VAL;
		sts[5] = `HIGH_SPEED_VAL;
		sts[4] = `CAP_LIST_VAL;
		sts[3] = intx;
		cmd = 16'h0000;
		cmd[`PARITY_RESPONSE_ENABLE_BIT] = pee;
	end

	// dword select; unmapped dwords read zero
	always_comb begin
		base = byte_addr & `DWORD_MASK;
		word = 32'h0000_0000;
		if (rd_addr) begin
			case (base)
				`OFF_CMD: begin
					word = {sts, cmd};
				end
				`OFF_RID: begin
					word = {`BASE_CLASS_VAL, `SUB_CLASS_VAL, `HOST_IF_VAL,
						`STEPPING_VAL};
				end
				`OFF_CLS: begin
					word = {8'h00, `MULTI_FUNC_VAL, `HDR_LAYOUT_VAL,
						`MLT_VAL, cache_line_size_reg};
				end
				default: begin
					word = 32'h0000_0000;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- hdl/pcie_config_header_status_ids.sv
// top of the configuration header slice: status, ids, class, cache line, header kind
`timescale 1ns/1ns
`default_nettype none
`include "cfg_hdr_defines.svh"

module pcie_config_header_status_ids (
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	// configuration access port
	input  wire logic                   cfg_rd,
	input  wire logic                   cfg_wr,
	input  wire cfg_hdr_pkg::cfg_addr_t cfg_addr,
	input  wire cfg_hdr_pkg::cfg_word_t cfg_wr_data,
	input  wire logic [3:0]             cfg_byte_en,
	output cfg_hdr_pkg::cfg_word_t      cfg_rd_data,
	output logic                        cfg_rd_valid,
	// error and interrupt events from the link logic
	input  wire logic                   parity_err_evt,
	input  wire logic                   system_err_evt,
	input  wire logic                   master_abort_evt,
	input  wire logic                   target_abort_evt,
	input  wire logic                   master_parity_evt,
	input  wire logic                   intx_asserted,
	// state for the rest of the device
	output logic                        parity_response_enable,
	output logic [7:0]                  cache_line_size_field
);
	import cfg_hdr_pkg::*;

	status_evt_if sef ();                 // flag bank carrier

	cfg_word_t  rd_word;                  // combinational read dword
	cfg_word_t  rd_data_q;                // registered read data
	logic       rd_valid_q;               // read answer strobe
	logic       pee_q;                    // parity response enable
	logic [7:0] cls_q;                    // cache line size
	cfg_addr_t  wr_base;                  // dword-aligned write address
	logic       wr_cmd_sts;               // write hits command/status dword
	logic       wr_cls;                   // write hits cache line dword
	flag_vec_t  set_vec;                  // flag set requests
	flag_vec_t  clr_vec;                  // flag clear requests
	logic [15:0] sts_wd;                  // status half of write data

	// write address decode
	always_comb begin
		wr_base    = cfg_addr & `DWORD_MASK;
		wr_cmd_sts = cfg_wr && (wr_base == `OFF_CMD);
		wr_cls     = cfg_wr && (wr_base == `OFF_CLS);
		sts_wd     = cfg_wr_data[31:16];
	end

	// hardware events mapped onto flag slots
	always_comb begin
		set_vec = 5'h00;
		set_vec[FLG_DPE] = parity_err_evt;
		set_vec[FLG_SSE] = system_err_evt;
		set_vec[FLG_RMA] = master_abort_evt;
		set_vec[FLG_RTA] = target_abort_evt;
		set_vec[FLG_DPD] = master_parity_evt && pee_q;
	end

	// write-one-to-clear, only the top status byte lane carries error flags
	always_comb begin
		clr_vec = 5'h00;
		if (wr_cmd_sts) begin
			clr_vec[FLG_DPE] = cfg_byte_en[3] && sts_wd[`STS_DPE_BIT];
			clr_vec[FLG_SSE] = cfg_byte_en[3] && sts_wd[`STS_SSE_BIT];
			clr_vec[FLG_RMA] = cfg_byte_en[3] && sts_wd[`STS_RMA_BIT];
			clr_vec[FLG_RTA] = cfg_byte_en[3] && sts_wd[`STS_RTA_BIT];
			clr_vec[FLG_DPD] = cfg_byte_en[3] && sts_wd[`STS_DPD_BIT];
		end
	end

	assign sef.evt = set_vec;
	assign sef.clr = clr_vec;

	// sticky error flags
	status_flags u_flags (
		.sys_clk (sys_clk),
		.srst    (srst),
		.sef     (sef)
	);

	// parity response enable, writable only when parity is supported
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pee_q <= `PEE_RST;
		end else if (wr_cmd_sts && cfg_byte_en[0]) begin
			pee_q <= cfg_wr_data[`PARITY_RESPONSE_ENABLE_BIT] & `PARITY_SUPPORTED;
		end
	end

	// cache line size keeps whatever software last wrote
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cls_q <= `CLS_RST;
		end else if (wr_cls && cfg_byte_en[0]) begin
			cls_q <= cfg_wr_data[7:0];
		end
	end

	// read dword assembly
	cfg_read_mux u_rmux (
		.rd_addr   (cfg_rd),
		.byte_addr (cfg_addr),
		.flags     (sef.flags),
		.pee       (pee_q),
		.intx      (intx_asserted),
		.cache_line_size_reg       (cls_q),
		.word      (rd_word)
	);

	// read data captured on request, answered one cycle later
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_data_q <= 32'h0000_0000;
		end else if (cfg_rd) begin
			rd_data_q <= rd_word;
		end
	end

	// read answer strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= cfg_rd;
		end
	end

	assign cfg_rd_data            = rd_data_q;
	assign cfg_rd_valid           = rd_valid_q;
	assign parity_response_enable = pee_q;
	assign cache_line_size_field  = cls_q;

	// helper: which dword the answered read addressed
	cfg_addr_t rd_base_q;                 // base address of last read
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_base_q <= 8'h00;
		end else if (cfg_rd) begin
			rd_base_q <= cfg_addr & `DWORD_MASK;
		end
	end

	// helper: interrupt level seen at the read request
	logic intx_at_rd_q;                   // sampled interrupt level
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			intx_at_rd_q <= 1'b0;
		end else if (cfg_rd) begin
			intx_at_rd_q <= intx_asserted;
		end
	end

	// every read answers on the next edge
	a_read_answer:
	assert property (@(posedge sys_clk) disable iff (srst)
		cfg_rd |=> cfg_rd_valid)
	else $error("read not answered in one cycle");

	// status read shows the unsupported bit at zero
	a_sta_zero:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CMD) |-> !cfg_rd_data[`STS_LSB + 11])
	else $error("signalled target abort bit not zero");

	// status read shows straps in place
	a_strap_bits:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CMD) |->
		(cfg_rd_data[`STS_LSB + 10 -: 2] == `SEL_TIMING_VAL) &&
		(cfg_rd_data[`STS_LSB + 7] == `FAST_B2B_VAL) &&
		(cfg_rd_data[`STS_LSB + 5] == `HIGH_SPEED_VAL))
	else $error("status strap bits wrong");

	// capability list always present
	a_cap_list_one:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CMD) |-> cfg_rd_data[`STS_LSB + 4])
	else $error("capability list bit not one");

	// interrupt status follows the interrupt level at request time
	a_int_status:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CMD) |->
		(cfg_rd_data[`STS_LSB + 3] == intx_at_rd_q))
	else $error("interrupt status mismatch");

	// reserved status bits never read one
	a_reserved_zero:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CMD) |->
		!cfg_rd_data[`STS_LSB + 6] && (cfg_rd_data[`STS_LSB + 2 -: 3] == 3'h0))
	else $error("reserved status bit set");

	// revision and class code dword is fixed
	a_class_code:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_RID) |->
		(cfg_rd_data == {`BASE_CLASS_VAL, `SUB_CLASS_VAL, `HOST_IF_VAL, `STEPPING_VAL}))
	else $error("revision or class code wrong");

	// latency timer and header kind are fixed
	a_header_kind:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd_valid && rd_base_q == `OFF_CLS) |->
		(cfg_rd_data[15:8] == `MLT_VAL) && (cfg_rd_data[23] == `MULTI_FUNC_VAL) &&
		(cfg_rd_data[22:16] == `HDR_LAYOUT_VAL))
	else $error("latency timer or header kind wrong");

	// cache line size takes the written byte and holds it
	a_cls_write:
	assert property (@(posedge sys_clk) disable iff (srst)
		(wr_cls && cfg_byte_en[0]) |=> (cls_q == $past(cfg_wr_data[7:0])) ##1
		($stable(cls_q) || $past(wr_cls && cfg_byte_en[0])))
	else $error("cache line size not stored or not held");

	// cache line size reads back its register
	a_cls_read:
	assert property (@(posedge sys_clk) disable iff (srst)
		(cfg_rd && (cfg_addr & `DWORD_MASK) == `OFF_CLS) |=> (cfg_rd_data[7:0] == $past(cls_q)))
	else $error("cache line size read back wrong");

	// parity enable follows a written command low byte
	a_pee_write:
	assert property (@(posedge sys_clk) disable iff (srst)
		(wr_cmd_sts && cfg_byte_en[0]) |=>
		(pee_q == ($past(cfg_wr_data[`PARITY_RESPONSE_ENABLE_BIT]) & `PARITY_SUPPORTED)))
	else $error("parity response enable not updated");

	// master parity fault ignored while reporting disabled
	a_dpd_gate:
	assert property (@(posedge sys_clk) disable iff (srst)
		(master_parity_evt && !pee_q && !sef.flags[FLG_DPD]) |=> !sef.flags[FLG_DPD])
	else $error("master parity flag set while disabled");

	// detected parity flag set regardless of enable and visible on read
	a_dpe_visible:
	assert property (@(posedge sys_clk) disable iff (srst)
		parity_err_evt ##1 (cfg_rd && (cfg_addr & `DWORD_MASK) == `OFF_CMD && !clr_vec[FLG_DPE])
		|=> cfg_rd_data[`STS_LSB + `STS_DPE_BIT])
	else $error("detected parity flag not visible");

	// main scenarios
	c_dpe_then_clear: cover property (@(posedge sys_clk) disable iff (srst)
		parity_err_evt ##[1:8] clr_vec[FLG_DPE]);
	c_dpd_enabled: cover property (@(posedge sys_clk) disable iff (srst)
		master_parity_evt && pee_q);
	c_cls_write_read: cover property (@(posedge sys_clk) disable iff (srst)
		wr_cls ##[1:4] (cfg_rd && (cfg_addr & `DWORD_MASK) == `OFF_CLS));
	c_abort_both: cover property (@(posedge sys_clk) disable iff (srst)
		master_abort_evt ##[0:4] target_abort_evt);
endmodule
`default_nettype wire

//--- dv/cfg_host_model.sv
// host-side model that issues configuration reads and writes
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
	input  wire logic                   sys_clk,
	output cfg_hdr_pkg::cfg_addr_t      cfg_addr,
	output cfg_hdr_pkg::cfg_word_t      cfg_wr_data,
	output logic                        cfg_rd,
	output logic                        cfg_wr,
	output logic [3:0]                  cfg_byte_en,
	input  wire cfg_hdr_pkg::cfg_word_t cfg_rd_data,
	input  wire logic                   cfg_rd_valid
);
	import cfg_hdr_pkg::*;
	bit held = 1'b0; // request left standing for a back-to-back follower
	// idle bus at time zero
	initial begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 8'h00;
		cfg_wr_data = 32'h0;
		cfg_byte_en = 4'h0;
	end
	// one request driven at a falling edge, answer taken one cycle later
	task automatic xfer(input logic rd, input logic wr, input cfg_addr_t a, input cfg_word_t d,
			input logic [3:0] be, input bit hold, output cfg_word_t q, output bit ok);
		if (!held) begin
			@(negedge sys_clk);
		end
		cfg_rd = rd;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_wr_data = d;
		cfg_byte_en = be;
		@(posedge sys_clk);
		@(negedge sys_clk);
		// answer strobe must match whether a read was taken
		ok = (cfg_rd_valid === rd);
		q = cfg_rd_data;
		held = hold;
		if (!hold) begin
			// released lines show garbage, not the last value
			cfg_rd = 1'b0;
			cfg_wr = 1'b0;
			cfg_addr = ~a;
			cfg_wr_data = ~d;
			cfg_byte_en = ~be;
		end
	endtask
endmodule
`default_nettype wire

//--- dv/pcie_config_header_status_ids_bench.sv
// self-checking bench of the configuration header slice
`timescale 1ns/1ns
`default_nettype none
`include "cfg_hdr_defines.svh"
module pcie_config_header_status_ids_bench;
	import cfg_hdr_pkg::*;
	logic       sys_clk = 1'b0;
	logic       srst    = 1'b1;
	logic       cfg_rd;
	logic       cfg_wr;
	logic       rd_valid;
	logic       pee_o;
	logic       intx    = 1'b0;
	logic [3:0] be;
	logic [4:0] ev      = 5'h00; // event pulses in flag index order
	logic [7:0] cls_o;
	cfg_addr_t  cfg_addr;
	cfg_word_t  cfg_wr_data;
	cfg_word_t  cfg_rd_data;
	cfg_word_t  q;
	bit         ok;
	int         mismatches = 0;
	int         n_checks   = 0;
	flag_vec_t  m_flg;       // model sticky flags
	logic       m_pee;       // model parity response enable
	logic [7:0] m_cls;       // model cache line size
	cfg_word_t  exp_q[$];    // expected read answers
	cfg_addr_t  addrs[8] = '{8'h04, 8'h06, 8'h08, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h3c};
	// write-one-to-clear request seen at this edge
	wire        w1c = cfg_wr && ((cfg_addr & 8'hfc) == 8'h04) && be[3];
	wire flag_vec_t clr = w1c ? {cfg_wr_data[31:28], cfg_wr_data[24]} : 5'h00;

	always #5 sys_clk = ~sys_clk;

	pcie_config_header_status_ids uut (
		.sys_clk(sys_clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_byte_en(be),
		.cfg_rd_data(cfg_rd_data), .cfg_rd_valid(rd_valid),
		.parity_err_evt(ev[4]), .system_err_evt(ev[3]), .master_abort_evt(ev[2]),
		.target_abort_evt(ev[1]), .master_parity_evt(ev[0]), .intx_asserted(intx),
		.parity_response_enable(pee_o), .cache_line_size_field(cls_o)
	);

	cfg_host_model host (
		.sys_clk(sys_clk), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd(cfg_rd),
		.cfg_wr(cfg_wr), .cfg_byte_en(be), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(rd_valid)
	);

	// expected dword from the model state at the taking edge
	function automatic cfg_word_t exp_word(input cfg_addr_t a);
		case (a & 8'hfc)
			8'h04: return {m_flg[FLG_DPE], m_flg[FLG_SSE], m_flg[FLG_RMA], m_flg[FLG_RTA], 1'b0,
				`SEL_TIMING_VAL, m_flg[FLG_DPD], `FAST_B2B_VAL, 1'b0, `HIGH_SPEED_VAL, 1'b1,
				intx, 3'h0, 9'h000, m_pee, 6'h00};
			8'h08: return {8'h01, 8'h08, 8'h02, `STEPPING_VAL};
			8'h0c: return {8'h00, `MULTI_FUNC_VAL, 7'h00, 8'h00, m_cls};
			default: return 32'h0;
		endcase
	endfunction

	// reference state stepped at every rising edge; set wins over clear
	always @(posedge sys_clk) begin
		if (srst) begin
			m_flg <= 5'h00;
			m_pee <= 1'b0;
			m_cls <= 8'h00;
		end else begin
			if (cfg_rd) begin
				exp_q.push_back(exp_word(cfg_addr));
			end
			m_flg <= (m_flg & ~clr) | {ev[4:1], ev[0] & m_pee};
			if (cfg_wr && ((cfg_addr & 8'hfc) == 8'h04) && be[0]) begin
				m_pee <= cfg_wr_data[6] & `PARITY_SUPPORTED;
			end
			if (cfg_wr && ((cfg_addr & 8'hfc) == 8'h0c) && be[0]) begin
				m_cls <= cfg_wr_data[7:0];
			end
		end
	end

	task automatic check(input cfg_word_t seen, input cfg_word_t exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access, then answer and side outputs against the model
	task automatic acc(input logic rd, input logic wr, input cfg_addr_t a, input cfg_word_t d,
			input logic [3:0] be, input bit hold);
		host.xfer(rd, wr, a, d, be, hold, q, ok);
		check({31'h0, ok}, 32'h1);
		if (rd) begin
			check(q, exp_q.pop_front());
		end
		check({23'h0, pee_o, cls_o}, {23'h0, m_pee, m_cls});
	endtask

	task automatic rd(input cfg_addr_t a);
		acc(1'b1, 1'b0, a, 32'h0, 4'h0, 1'b0);
	endtask

	task automatic wr(input cfg_addr_t a, input cfg_word_t d, input logic [3:0] b);
		acc(1'b0, 1'b1, a, d, b, 1'b0);
	endtask

	task automatic pulse(input logic [4:0] e);
		@(negedge sys_clk);
		ev = e;
		@(negedge sys_clk);
		ev = 5'h00;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		#100000;
		mismatches++;
		close_out();
	end

	initial begin
		void'($urandom(32'h8577));
		repeat (8) @(negedge sys_clk);
		srst = 1'b0;
		// reset values, fixed fields, unmapped places
		foreach (addrs[i]) rd(addrs[i]);
		// each event twice, enable on only for the master parity pulse of the second pass; clear needs the top lane
		for (int p = 0; p < 2; p++) begin
			wr(8'h04, 32'(p) << 6, 4'h1);
			for (int i = 0; i < 5; i++) begin
				pulse(5'(1 << i));
				rd(8'h04);
				wr(8'h04, 32'hf100_0000, 4'h7);
				rd(8'h04);
				wr(8'h04, 32'hffff_ffbf, 4'h8);
				rd(8'h04);
			end
		end
		// event at the clearing edge keeps four flags; master parity is still gated off by the enable
		fork
			wr(8'h04, 32'hf100_0040, 4'hf);
			pulse(5'h1f);
		join
		rd(8'h04);
		intx = 1'b1;
		rd(8'h04);
		intx = 1'b0;
		rd(8'h06);
		// read-only places ignore writes; cache line size lane only
		wr(8'h08, 32'hffff_ffff, 4'hf);
		wr(8'h0c, 32'hffff_ff5a, 4'hf);
		wr(8'h0c, 32'h0000_00a5, 4'he);
		rd(8'h08);
		rd(8'h0d);
		// read with write in one cycle, then back to back reads
		acc(1'b1, 1'b1, 8'h0c, 32'h0000_003c, 4'h1, 1'b0);
		acc(1'b1, 1'b0, 8'h04, 32'h0, 4'h0, 1'b1);
		acc(1'b1, 1'b0, 8'h0c, 32'h0, 4'h0, 1'b1);
		acc(1'b1, 1'b0, 8'h09, 32'h0, 4'h0, 1'b0);
		// mid-run reset clears flags and cache line size
		pulse(5'h1f);
		@(negedge sys_clk);
		srst = 1'b1;
		@(negedge sys_clk);
		srst = 1'b0;
		rd(8'h04);
		rd(8'h0c);
		// random traffic against random events
		repeat (300) begin
			ev = 5'($urandom() & $urandom() & $urandom());
			intx = 1'($urandom());
			acc(1'($urandom()), 1'($urandom()), addrs[$urandom() % 8], $urandom(),
				4'($urandom()), 1'($urandom()));
		end
		ev = 5'h00;
		rd(8'h04);
		close_out();
	end
endmodule
`default_nettype wire
